// file: rtl/spar_params.svh
// Register map, field positions and timing counts for the serial port
`ifndef SPAR_PARAMS_SVH
`define SPAR_PARAMS_SVH
`define SPAR_AW          12
`define SPAR_LANE        2'b00
`define SPAR_IDX_CTRL    10'h001
`define SPAR_IDX_BUF     10'h002
`define SPAR_IDX_PWR     10'h003
`define SPAR_IDX_SLAVE_ADDRESS   10'h0a9
`define SPAR_IDX_SLAVE_ADDRESS_MASK   10'h0b9
`define SPAR_ADDR_RST    8'h00
`define SPAR_CTRL_TOP    7
`define SPAR_PWR_BD      7
`define SPAR_PWR_VIEW    6
`define SPAR_M0_SLOW     4'hc
`define SPAR_M0_FAST     4'h4
`define SPAR_M0_LAST     4'h7
`define SPAR_M2_DIV_SLOW 2'h3
`define SPAR_M2_DIV_FAST 2'h1
`define SPAR_SUB_LAST    4'hf
`define SPAR_SMP_FIRST   4'h7
`define SPAR_SMP_LAST    4'h9
`define SPAR_LEN_10      4'ha
`define SPAR_LEN_11      4'hb
`endif

// file: rtl/spar_pkg.sv
// Types shared by the serial port design
`include "spar_params.svh"
package spar_pkg;
	typedef enum logic [1:0] {
		MODE_SHIFT, MODE_ASYNC10, MODE_ASYNC11, MODE_ASYNC11T
	} spar_mode_t;
	typedef enum logic [2:0] {
		REG_NONE, REG_CTRL, REG_BUF, REG_PWR, REG_SLAVE_ADDRESS, REG_SLAVE_ADDRESS_MASK
	} spar_reg_t;
	typedef enum logic [1:0] {SYNC_IDLE, SYNC_TX, SYNC_RX} spar_sync_t;
	typedef enum logic {RX_HUNT, RX_FRAME} spar_rx_t;
	typedef struct packed {
		logic modeLow;
		logic modeHigh;
		logic addrMatchEn;
		logic rxEnable;
		logic txNinth;
		logic rxNinth;
		logic txDone;
		logic rxDone;
	} spar_ctrl_t;
	typedef struct packed {
		logic [`SPAR_AW-1:0] addr;
		logic                write;
	} spar_ahb_req_t;
endpackage : spar_pkg

// file: rtl/spar_serial_port.sv
// Serial port with framing error check and address recognition
// Function
// - Load only when done clear and gate open
// - Load ninth bit, byte, set done
// - After stop middle, hunt for falling edge
// - Mode 3 is mode 2 on timer ticks
// - Buffer write starts transmission in every mode
// - Mode 0 receive starts when enabled, done clear
// - Async receive starts on start bit, enabled
// - Two mode bits select the four modes
// - Missing stop bit flags frame error
// - Control bit 7 shows error or mode
// - Frame error sticky until software write
// - Modes 2/3 filter: ninth high, address match
// - Mode 1 filter: valid stop, address match
// - Filter off: every frame sets done
// - Given address: masked compare of slave address
// - Broadcast: OR of address and mask
// - Address and mask reset to zero
// - Majority of samples 7,8,9; bad start aborts
// - Mode 0 rate: twelfth or quarter clock
// - Mode 2 rate: 1/32 or 1/64 clock
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "spar_params.svh"
module spar_serial_port (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Baud source from the timer
	input  wire logic        timerOvf,
	// Serial pins
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOe,
	output logic             txdOut
);
	spar_pkg::spar_ctrl_t    ctrl_reg;
	spar_pkg::spar_ahb_req_t req_reg;
	spar_pkg::spar_mode_t    mode;
	spar_pkg::spar_sync_t    syncState_reg;
	spar_pkg::spar_rx_t      rxState_reg;
	spar_pkg::spar_reg_t     wrSel;
	logic        dpValid_reg;
	logic        rdReady_reg;
	logic        frameErr_reg;
	logic        baudDouble_reg;
	logic        viewSel_reg;
	logic [7:0]  slaveAddr_reg;
	logic [7:0]  slaveMask_reg;
	logic [7:0]  rxBuf_reg;
	logic [31:0] rdWord;
	logic        wrEn;
	logic        wrCtrl;
	logic        wrBuf;
	logic [1:0]  div_reg;
	logic        ovfHalf_reg;
	logic        tick;
	logic [3:0]  frameLen;
	logic        txBusy_reg;
	logic [3:0]  txSub_reg;
	logic [3:0]  txCnt_reg;
	logic [10:0] txShift_reg;
	logic        txLine_reg;
	logic        txdPin_reg;
	logic        rxdPin_reg;
	logic        rxdOePin_reg;
	logic        setTx;
	logic        rxMeta_reg;
	logic        rxSync_reg;
	logic        rxPrev_reg;
	logic [3:0]  rxSub_reg;
	logic [3:0]  rxCnt_reg;
	logic [1:0]  votes_reg;
	logic [8:0]  rxData_reg;
	logic        vote;
	logic        bitDone;
	logic        stopDecide;
	logic [7:0]  rxByte;
	logic        ninthBit;
	logic [7:0]  bcast;
	logic        addrOk;
	logic        loadAsync;
	logic        setRx;
	logic [3:0]  phase_reg;
	logic [3:0]  syncCnt_reg;
	logic [7:0]  syncShift_reg;
	logic        shiftClk_reg;
	logic [3:0]  period;
	logic [3:0]  fallAt;
	logic [3:0]  riseAt;
	logic        syncDone;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	function automatic spar_pkg::spar_reg_t regDecode(
		input logic [`SPAR_AW-1:0] a);
		case (a)
			{`SPAR_IDX_CTRL, `SPAR_LANE}:  regDecode = spar_pkg::REG_CTRL;
			{`SPAR_IDX_BUF, `SPAR_LANE}:   regDecode = spar_pkg::REG_BUF;
			{`SPAR_IDX_PWR, `SPAR_LANE}:   regDecode = spar_pkg::REG_PWR;
			{`SPAR_IDX_SLAVE_ADDRESS, `SPAR_LANE}: regDecode = spar_pkg::REG_SLAVE_ADDRESS;
			{`SPAR_IDX_SLAVE_ADDRESS_MASK, `SPAR_LANE}: regDecode = spar_pkg::REG_SLAVE_ADDRESS_MASK;
			default:                       regDecode = spar_pkg::REG_NONE;
		endcase
	endfunction : regDecode

	// Zero bits of the care mask never block a match
	function automatic logic addrHit(input logic [7:0] b,
		input logic [7:0] a, input logic [7:0] care);
		addrHit = ((b ^ a) & care) == 8'h00;
	endfunction : addrHit

	// Bus slave: writes take no wait, reads one so data is fresh
	assign hreadyout = ~(dpValid_reg & ~req_reg.write) | rdReady_reg;
	assign hresp = 1'b0;
	assign wrSel = regDecode(req_reg.addr);
	assign wrEn = dpValid_reg & req_reg.write;
	assign wrCtrl = wrEn && wrSel == spar_pkg::REG_CTRL;
	assign wrBuf = wrEn && wrSel == spar_pkg::REG_BUF;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			req_reg <= '0;
			dpValid_reg <= 1'b0;
			rdReady_reg <= 1'b0;
		end else if (hready) begin
			req_reg.addr <= haddr[`SPAR_AW-1:0];
			req_reg.write <= hwrite;
			dpValid_reg <= hsel & htrans[1];
			rdReady_reg <= 1'b0;
		end else if (dpValid_reg) begin
			rdReady_reg <= 1'b1;
		end
	end

	always_comb begin
		rdWord = 32'h0000_0000;
		case (wrSel)
			spar_pkg::REG_CTRL: begin
				rdWord[7:0] = ctrl_reg;
				rdWord[`SPAR_CTRL_TOP] = viewSel_reg ? frameErr_reg
					: ctrl_reg.modeLow;
			end
			spar_pkg::REG_BUF:   rdWord[7:0] = rxBuf_reg;
			spar_pkg::REG_PWR: begin
				rdWord[`SPAR_PWR_BD] = baudDouble_reg;
				rdWord[`SPAR_PWR_VIEW] = viewSel_reg;
			end
			spar_pkg::REG_SLAVE_ADDRESS: rdWord[7:0] = slaveAddr_reg;
			spar_pkg::REG_SLAVE_ADDRESS_MASK: rdWord[7:0] = slaveMask_reg;
			default:             rdWord = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (dpValid_reg && !req_reg.write && !rdReady_reg) begin
			hrdata <= rdWord;
		end
	end

	// Address, mask and power control
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			slaveAddr_reg <= `SPAR_ADDR_RST;
			slaveMask_reg <= `SPAR_ADDR_RST;
			baudDouble_reg <= 1'b0;
			viewSel_reg <= 1'b0;
		end else if (wrEn) begin
			if (wrSel == spar_pkg::REG_SLAVE_ADDRESS)
				slaveAddr_reg <= hwdata[7:0];
			if (wrSel == spar_pkg::REG_SLAVE_ADDRESS_MASK)
				slaveMask_reg <= hwdata[7:0];
			if (wrSel == spar_pkg::REG_PWR) begin
				baudDouble_reg <= hwdata[`SPAR_PWR_BD];
				viewSel_reg <= hwdata[`SPAR_PWR_VIEW];
			end
		end
	end

	// Control: hardware sets win over a same-cycle software clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_reg <= spar_pkg::spar_ctrl_t'(hwdata[7:0]);
				if (viewSel_reg)
					ctrl_reg.modeLow <= ctrl_reg.modeLow;
			end
			if (setRx)
				ctrl_reg.rxDone <= 1'b1;
			if (loadAsync)
				ctrl_reg.rxNinth <= ninthBit;
			if (setTx)
				ctrl_reg.txDone <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			frameErr_reg <= 1'b0;
		end else begin
			if (wrCtrl && viewSel_reg)
				frameErr_reg <= hwdata[`SPAR_CTRL_TOP];
			if (stopDecide && !vote)
				frameErr_reg <= 1'b1;
		end
	end
	a_fe_on_bad_stop: assert property (
		stopDecide && !vote |=> frameErr_reg)
		else $error("frame error not flagged");
	a_fe_sticky: assert property (
		frameErr_reg && !wrCtrl |=> frameErr_reg)
		else $error("frame error cleared by hardware");

	// Baud ticks at sixteen per bit
	assign mode = spar_pkg::spar_mode_t'({ctrl_reg.modeHigh,
		ctrl_reg.modeLow});
	always_comb begin
		case (mode)
			spar_pkg::MODE_ASYNC11: tick = div_reg == 2'h0;
			spar_pkg::MODE_ASYNC10, spar_pkg::MODE_ASYNC11T:
				tick = timerOvf & (baudDouble_reg | ovfHalf_reg);
			default: tick = 1'b0;
		endcase
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 2'h0;
			ovfHalf_reg <= 1'b0;
		end else begin
			if (div_reg == 2'h0)
				div_reg <= baudDouble_reg ? `SPAR_M2_DIV_FAST
					: `SPAR_M2_DIV_SLOW;
			else
				div_reg <= div_reg - 2'h1;
			if (timerOvf)
				ovfHalf_reg <= ~ovfHalf_reg;
		end
	end
	a_m2_fast_rate: assert property (tick && baudDouble_reg
		&& mode == spar_pkg::MODE_ASYNC11 |=> !tick)
		else $error("mode 2 fast tick spacing wrong");
	a_m2_slow_rate: assert property (tick && !baudDouble_reg
		&& mode == spar_pkg::MODE_ASYNC11 |=> !tick [*3])
		else $error("mode 2 slow tick spacing wrong");

	assign frameLen = (mode == spar_pkg::MODE_ASYNC10) ? `SPAR_LEN_10
		: `SPAR_LEN_11;

	// Async transmitter, paced by its own divide-by-16
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txBusy_reg <= 1'b0;
			txSub_reg <= 4'h0;
			txCnt_reg <= 4'h0;
			txShift_reg <= 11'h7ff;
			txLine_reg <= 1'b1;
		end else begin
			if (tick)
				txSub_reg <= txSub_reg + 4'h1;
			if (wrBuf && mode != spar_pkg::MODE_SHIFT) begin
				txBusy_reg <= 1'b1;
				txCnt_reg <= 4'h0;
				if (mode == spar_pkg::MODE_ASYNC10)
					txShift_reg <= {2'b11, hwdata[7:0], 1'b0};
				else
					txShift_reg <= {1'b1, ctrl_reg.txNinth,
						hwdata[7:0], 1'b0};
			end else if (txBusy_reg && tick
				&& txSub_reg == `SPAR_SUB_LAST) begin
				txLine_reg <= txShift_reg[0];
				txShift_reg <= {1'b1, txShift_reg[10:1]};
				txCnt_reg <= txCnt_reg + 4'h1;
				if (txCnt_reg == frameLen - 4'h1)
					txBusy_reg <= 1'b0;
			end
		end
	end
	assign setTx = (txBusy_reg && tick && txSub_reg == `SPAR_SUB_LAST
		&& txCnt_reg == frameLen - 4'h1 && !wrBuf)
		|| (syncDone && syncState_reg == spar_pkg::SYNC_TX);
	a_tx_start: assert property (wrBuf && syncState_reg ==
		spar_pkg::SYNC_IDLE |=> txBusy_reg
		|| syncState_reg == spar_pkg::SYNC_TX)
		else $error("buffer write did not start transmit");

	// Receive pin synchroniser; the second stage is the data, the third finds the edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxMeta_reg <= 1'b1;
			rxSync_reg <= 1'b1;
			rxPrev_reg <= 1'b1;
		end else begin
			rxMeta_reg <= rxdIn;
			rxSync_reg <= rxMeta_reg;
			rxPrev_reg <= rxSync_reg;
		end
	end

	// Async receiver
	assign vote = (votes_reg[1] & votes_reg[0]) | (votes_reg[1] & rxSync_reg)
		| (votes_reg[0] & rxSync_reg);
	assign bitDone = rxState_reg == spar_pkg::RX_FRAME && tick
		&& rxSub_reg == `SPAR_SMP_LAST;
	assign stopDecide = bitDone && rxCnt_reg == frameLen - 4'h1;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rxState_reg <= spar_pkg::RX_HUNT;
			rxSub_reg <= 4'h0;
			rxCnt_reg <= 4'h0;
			votes_reg <= 2'b11;
			rxData_reg <= 9'h000;
		end else begin
			case (rxState_reg)
				spar_pkg::RX_HUNT: begin
					if (ctrl_reg.rxEnable && mode != spar_pkg::MODE_SHIFT
						&& rxPrev_reg && !rxSync_reg) begin
						rxState_reg <= spar_pkg::RX_FRAME;
						rxSub_reg <= 4'h0;
						rxCnt_reg <= 4'h0;
					end
				end
				spar_pkg::RX_FRAME: begin
					if (tick)
						rxSub_reg <= rxSub_reg + 4'h1;
					if (tick && rxSub_reg >= `SPAR_SMP_FIRST
						&& rxSub_reg < `SPAR_SMP_LAST)
						votes_reg <= {votes_reg[0], rxSync_reg};
					if (bitDone) begin
						rxCnt_reg <= rxCnt_reg + 4'h1;
						if (rxCnt_reg == 4'h0 && vote)
							rxState_reg <= spar_pkg::RX_HUNT;
						else if (stopDecide)
							rxState_reg <= spar_pkg::RX_HUNT;
						else if (rxCnt_reg != 4'h0)
							rxData_reg <= {vote, rxData_reg[8:1]};
					end
				end
				default: rxState_reg <= spar_pkg::RX_HUNT;
			endcase
		end
	end
	a_hunt_after_stop: assert property (stopDecide
		|=> rxState_reg == spar_pkg::RX_HUNT)
		else $error("receiver not hunting after stop");
	a_no_rx_disabled: assert property (rxState_reg == spar_pkg::RX_HUNT
		&& !ctrl_reg.rxEnable |=> rxState_reg == spar_pkg::RX_HUNT)
		else $error("reception started while disabled");

	// Load decision and address recognition at the stop bit
	assign rxByte = (mode == spar_pkg::MODE_ASYNC10) ? rxData_reg[8:1]
		: rxData_reg[7:0];
	assign ninthBit = (mode == spar_pkg::MODE_ASYNC10) ? vote
		: rxData_reg[8];
	assign bcast = slaveAddr_reg | slaveMask_reg;
	assign addrOk = addrHit(rxByte, slaveAddr_reg, slaveMask_reg)
		|| addrHit(rxByte, bcast, bcast);
	assign loadAsync = stopDecide && !ctrl_reg.rxDone
		&& (!ctrl_reg.addrMatchEn || (ninthBit && addrOk));
	assign setRx = loadAsync
		|| (syncDone && syncState_reg == spar_pkg::SYNC_RX);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rxBuf_reg <= 8'h00;
		else if (loadAsync)
			rxBuf_reg <= rxByte;
		else if (syncDone && syncState_reg == spar_pkg::SYNC_RX)
			rxBuf_reg <= syncShift_reg;
	end
	a_done_blocks_load: assert property (ctrl_reg.rxDone && !wrCtrl
		&& syncState_reg != spar_pkg::SYNC_RX |=> $stable(rxBuf_reg))
		else $error("buffer loaded while done flag set");
	a_done_has_cause: assert property ($rose(ctrl_reg.rxDone)
		&& !$past(wrCtrl) |-> $past(setRx))
		else $error("done flag rose without a load");
	a_addr_filter: assert property (stopDecide && ctrl_reg.addrMatchEn
		&& mode[1] && !rxData_reg[8] |=> $stable(rxBuf_reg))
		else $error("address frame filter failed");

	// Mode 0 shift engine drives the clock on the transmit pin
	assign period = ctrl_reg.addrMatchEn ? `SPAR_M0_FAST
		: `SPAR_M0_SLOW;
	// One clock early: the pin flops add that clock back
	assign fallAt = (period >> 2) - 4'h1;
	assign riseAt = fallAt + (period >> 1);
	assign syncDone = syncState_reg != spar_pkg::SYNC_IDLE
		&& phase_reg == period - 4'h1 && syncCnt_reg == `SPAR_M0_LAST;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncState_reg <= spar_pkg::SYNC_IDLE;
			phase_reg <= 4'h0;
			syncCnt_reg <= 4'h0;
			syncShift_reg <= 8'hff;
			shiftClk_reg <= 1'b1;
		end else begin
			case (syncState_reg)
				spar_pkg::SYNC_IDLE: begin
					phase_reg <= 4'h0;
					syncCnt_reg <= 4'h0;
					if (mode == spar_pkg::MODE_SHIFT && wrBuf) begin
						syncState_reg <= spar_pkg::SYNC_TX;
						syncShift_reg <= hwdata[7:0];
					end else if (mode == spar_pkg::MODE_SHIFT
						&& ctrl_reg.rxEnable && !ctrl_reg.rxDone) begin
						syncState_reg <= spar_pkg::SYNC_RX;
					end
				end
				spar_pkg::SYNC_TX, spar_pkg::SYNC_RX: begin
					phase_reg <= phase_reg + 4'h1;
					if (phase_reg == fallAt)
						shiftClk_reg <= 1'b0;
					if (phase_reg == riseAt) begin
						shiftClk_reg <= 1'b1;
						if (syncState_reg == spar_pkg::SYNC_RX)
							syncShift_reg <= {rxSync_reg,
								syncShift_reg[7:1]};
					end
					if (phase_reg == period - 4'h1) begin
						phase_reg <= 4'h0;
						syncCnt_reg <= syncCnt_reg + 4'h1;
						if (syncState_reg == spar_pkg::SYNC_TX)
							syncShift_reg <= {1'b1, syncShift_reg[7:1]};
						if (syncDone)
							syncState_reg <= spar_pkg::SYNC_IDLE;
					end
				end
				default: syncState_reg <= spar_pkg::SYNC_IDLE;
			endcase
		end
	end
	a_sync_rx_start: assert property (mode == spar_pkg::MODE_SHIFT
		&& syncState_reg == spar_pkg::SYNC_IDLE && ctrl_reg.rxEnable
		&& !ctrl_reg.rxDone && !wrBuf
		|=> syncState_reg == spar_pkg::SYNC_RX)
		else $error("mode 0 reception did not start");

	// Pins
	// All pins pass one flop so shift clock and data stay aligned
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			txdPin_reg <= 1'b1;
			rxdPin_reg <= 1'b1;
			rxdOePin_reg <= 1'b0;
		end else begin
			txdPin_reg <= (mode == spar_pkg::MODE_SHIFT) ? shiftClk_reg
				: txLine_reg;
			rxdPin_reg <= syncShift_reg[0];
			rxdOePin_reg <= syncState_reg == spar_pkg::SYNC_TX;
		end
	end
	assign txdOut = txdPin_reg;
	assign rxdOut = rxdPin_reg;
	assign rxdOe = rxdOePin_reg;
endmodule : spar_serial_port

// file: verif/spar_far_end.sv
// Far-end transmitter model driving the port's receive line
`timescale 1ns/1ps
module spar_far_end (
	// Clock
	input  wire logic core_clk,
	// Receive line of the port, driven high when idle
	output logic      lineOut
);
	initial lineOut = 1'b1;

	// One frame, LSB first; bitClk sets a prompt or a slow sender
	task automatic send(input logic [7:0] b, input logic ninth,
		input logic eleven, input logic stopBit, input int bitClk);
		logic [10:0] f;
		int          n;
		f = eleven ? {stopBit, ninth, b, 1'b0} : {1'b1, stopBit, b, 1'b0};
		n = eleven ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			lineOut <= f[i];
			repeat (bitClk) @(posedge core_clk);
		end
		// Idle gap so the next start edge is clean
		lineOut <= 1'b1;
		repeat (bitClk) @(posedge core_clk);
	endtask : send
endmodule : spar_far_end

// file: verif/test_spar_serial_port.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "spar_params.svh"
module test_spar_serial_port;
	localparam logic [11:0] A_CT = {`SPAR_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_BF = {`SPAR_IDX_BUF, 2'b00};
	localparam logic [11:0] A_PW = {`SPAR_IDX_PWR, 2'b00};
	localparam logic [11:0] A_SA = {`SPAR_IDX_SLAVE_ADDRESS, 2'b00};
	localparam logic [11:0] A_SM = {`SPAR_IDX_SLAVE_ADDRESS_MASK, 2'b00};
	localparam logic [7:0]  MD [4] = '{8'h40, 8'h40, 8'hc0, 8'h80};
	localparam logic [7:0]  PW [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
	localparam int          PER [4] = '{64, 32, 64, 64};
	localparam logic [7:0]  AB [5] = '{8'ha0, 8'ha2, 8'ha0, 8'hff, 8'ha5};
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        timerOvf = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rxdOut;
	logic        rxdOe;
	logic        txdOut;
	logic        farLine;
	logic        rxdLine;
	logic [31:0] rd;
	logic [7:0]  b;
	logic [10:0] f;
	logic        nin;
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          t0;
	int          t1;

	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;
	// Overflow pulse every second clock keeps timer modes at 64 clk a bit
	always @(posedge core_clk) timerOvf <= ~timerOvf;
	assign rxdLine = rxdOe ? rxdOut : farLine;

	spar_serial_port uut (
		.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .timerOvf(timerOvf), .rxdIn(rxdLine), .rxdOut(rxdOut),
		.rxdOe(rxdOe), .txdOut(txdOut)
	);
	spar_far_end far (.core_clk(core_clk), .lineOut(farLine));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t %s %h/%h", $time, what, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Ready is judged just before the edge, where it has settled
	task automatic wait_rdy();
		logic r;
		int   n;
		n = 0;
		do begin
			@(negedge core_clk);
			r = hreadyout;
			rd = hrdata;
			@(posedge core_clk);
			n++;
		end while (r !== 1'b1 && n < 50);
		check({31'h0, r}, 32'h1, "bus ready");
		check({31'h0, hresp}, 32'h0, "bus okay");
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		wait_rdy();
	endtask : bus

	task automatic rchk(input logic [11:0] a, input logic [7:0] m,
		input logic [7:0] e, input string w);
		bus(1'b0, a, 8'h00);
		check(rd & {24'h0, m}, {24'h0, e & m}, w);
	endtask : rchk

	task automatic frame(input logic [7:0] fb, input logic n9,
		input logic eleven, input logic stp, input int per);
		@(posedge core_clk);
		far.send(fb, n9, eleven, stp, per);
		repeat (8) @(posedge core_clk);
	endtask : frame

	task automatic fall(output int t, input logic up = 1'b0);
		logic p;
		int   n;
		n = 0;
		do begin
			p = txdOut;
			@(negedge core_clk);
			n++;
		end while (!(p === !up && txdOut === up) && n < 4000);
		t = cyc;
	endtask : fall

	function automatic logic hit(input logic [7:0] x, input logic [7:0] sa,
		input logic [7:0] sm);
		return (((x ^ sa) & sm) == 8'h00) || ((x & (sa | sm)) == (sa | sm));
	endfunction : hit

	initial begin
		repeat (60000) @(posedge core_clk);
		fails++;
		wrap_up();
	end

	initial begin
		void'($urandom(32'h09024d79));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		rchk(A_SA, 8'hff, 8'h00, "addr reset");
		rchk(A_SM, 8'hff, 8'h00, "mask reset");
		b = 8'($urandom);
		bus(1'b1, A_SA, b);
		rchk(A_SA, 8'hff, b, "addr rw");
		bus(1'b1, 12'h100, 8'h5a);
		rchk(12'h100, 8'hff, 8'h00, "unmapped");
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			nin = 1'($urandom);
			bus(1'b1, A_PW, PW[i]);
			bus(1'b1, A_CT, MD[i] | 8'h10);
			frame(b, nin, MD[i][6], 1'b1, PER[i]);
			rchk(A_BF, 8'hff, b, "rx byte");
			rchk(A_CT, 8'hff, MD[i] | 8'h11 | {5'h0, MD[i][6] ? nin : 1'b1,
				2'b00}, "rx ctrl");
			frame(~b, nin, MD[i][6], 1'b1, PER[i]);
			rchk(A_BF, 8'hff, b, "rx kept");
		end
		$display("test modes done");
		bus(1'b1, A_PW, 8'h00);
		bus(1'b1, A_SA, 8'ha4);
		bus(1'b1, A_SM, 8'hfa);
		for (int i = 0; i < 7; i++) begin
			b = (i < 5) ? AB[i] : 8'($urandom);
			nin = (i != 2);
			bus(1'b1, A_CT, 8'h70);
			frame(b, nin, 1'b1, 1'b1, 64);
			rchk(A_CT, 8'h01, {7'h0, nin & hit(b, 8'ha4, 8'hfa)},
				"filter");
		end
		for (int j = 0; j < 2; j++) begin
			bus(1'b1, A_CT, 8'hb0);
			frame(8'ha0, 1'b0, 1'b0, j == 0, 64);
			rchk(A_CT, 8'h01, {7'h0, j == 0}, "mode1 filter");
		end
		$display("test filter done");
		bus(1'b1, A_PW, 8'h40);
		bus(1'b1, A_CT, 8'h50);
		rchk(A_CT, 8'h80, 8'h00, "fe clear");
		frame(8'h3c, 1'b0, 1'b1, 1'b0, 64);
		rchk(A_CT, 8'h80, 8'h80, "fe set");
		frame(8'hc3, 1'b0, 1'b1, 1'b1, 64);
		rchk(A_CT, 8'h80, 8'h80, "fe sticky");
		bus(1'b1, A_CT, 8'h50);
		rchk(A_CT, 8'h80, 8'h00, "fe write");
		bus(1'b1, A_PW, 8'h00);
		rchk(A_CT, 8'h80, 8'h80, "mode view");
		$display("test frame error done");
		bus(1'b1, A_CT, 8'h48);
		b = 8'($urandom);
		f = {2'b11, b, 1'b0};
		bus(1'b1, A_BF, b);
		fall(t0);
		repeat (32) @(negedge core_clk);
		for (int k = 0; k < 11; k++) begin
			check({31'h0, txdOut}, {31'h0, f[k]}, "tx bit");
			repeat (64) @(negedge core_clk);
		end
		rchk(A_CT, 8'h02, 8'h02, "tx done");
		$display("test transmit done");
		for (int a = 0; a < 2; a++) begin
			// Far end holds its line low through the second run
			if (a == 1)
				fork
					far.send(8'h00, 1'b0, 1'b1, 1'b0, 16);
				join_none
			bus(1'b1, A_CT, (a == 1) ? 8'h30 : 8'h10);
			fall(t0);
			fall(t1);
			check(32'(t1 - t0), (a == 1) ? 32'd4 : 32'd12, "m0 rate");
			repeat (120) @(posedge core_clk);
			rchk(A_CT, 8'h01, 8'h01, "m0 done");
			rchk(A_BF, 8'hff, (a == 1) ? 8'h00 : 8'hff, "m0 byte");
		end
		b = 8'($urandom);
		bus(1'b1, A_BF, b);
		for (int k = 0; k < 8; k++) begin
			fall(t0, 1'b1);
			check({31'h0, rxdOe}, 32'h1, "m0 drive");
			check({31'h0, rxdOut}, {31'h0, b[k]}, "m0 tx bit");
		end
		repeat (4) @(negedge core_clk);
		check({31'h0, rxdOe}, 32'h0, "m0 release");
		rchk(A_CT, 8'h02, 8'h02, "m0 tx done");
		$display("test shift mode done");
		wrap_up();
	end
endmodule : test_spar_serial_port
